// ==== src/external_bus_interface.sv ====
// External bus interface: carries internal bus cycles onto the expansion pins.
// Assumes synchronous inputs, one bus cycle per access, and config held static.
`timescale 1ns/1ps
module external_bus_interface
  import ext_bus_pkg::*;
#(
  parameter bit INTERFACE_BUILD_ENABLE = 1'b1
) (
  input  wire logic                        clk_sys,
  input  wire logic                        srst,
  input  wire logic [ext_bus_pkg::ADDR_W-1:0] internal_address_in,
  input  wire logic [ext_bus_pkg::DATA_W-1:0] internal_data_in,
  output logic      [ext_bus_pkg::DATA_W-1:0] internal_data_bus,
  input  wire logic                        internal_read_write,
  input  wire logic                        cycle_valid,
  input  wire logic                        internal_space_hit,
  output logic                             internal_wait_request,
  input  wire logic                        low_noise_mode,
  input  wire logic                        internal_cycle_visibility,
  input  wire logic [1:0]                  region_map,
  input  wire logic                        prog_select_enable,
  input  wire logic                        prog_select_polarity,
  input  wire logic [1:0]                  prog_wait_count,
  input  wire logic                        prog_wait_write,
  input  wire logic                        gen_select_enable,
  input  wire logic                        gen_select_polarity,
  input  wire logic [2:0]                  gen_wait_count,
  input  wire logic                        gen_wait_write,
  input  wire logic                        gen_wait_external,
  input  wire logic [1:0]                  strobe_function,
  output logic      [ext_bus_pkg::ADDR_W-1:0] ext_addr,
  output logic                             ext_addr_oe_n,
  output logic      [ext_bus_pkg::DATA_W-1:0] ext_data_out,
  input  wire logic [ext_bus_pkg::DATA_W-1:0] ext_data_in,
  output logic                             ext_data_oe_n,
  output logic                             external_read_strobe_n,
  output logic                             external_write_strobe_n,
  output logic                             program_region_select,
  output logic                             general_region_select,
  output logic                             wait_value_drive_strobe,
  output logic                             wait_value_drive_strobe_oe_n,
  output logic                             external_access
);
  import ext_bus_pkg::*;

  logic [15:0]  prog_lo;
  logic [15:0]  gen_lo;
  logic         prog_hit_n;
  logic         gen_hit_n;
  logic         ext_cycle;
  logic         visible;
  logic         active;
  logic [1:0]   prog_ws_reg;
  logic [2:0]   gen_ws_reg;
  phase_t       phase_reg;
  logic         load_wait;
  logic [2:0]   wait_sel;
  logic         cnt_busy;
  logic         cur_gen_reg;
  logic [15:0]  addr_reg;
  logic [7:0]   dout_reg;
  logic [7:0]   idb_reg;
  logic         drive_reg;
  logic         rd_reg;
  logic         wr_reg;
  logic         psel_reg;
  logic         gsel_reg;
  logic         read_capture;

  // Region bounds for the chosen map
  always_comb begin
    unique case (region_map)
      MAP_A: begin prog_lo = PROG_LO_A; gen_lo = GEN_LO_A; end
      MAP_B: begin prog_lo = PROG_LO_B; gen_lo = GEN_LO_B; end
      MAP_C: begin prog_lo = PROG_LO_C; gen_lo = GEN_LO_C; end
      MAP_D: begin prog_lo = PROG_LO_D; gen_lo = GEN_LO_D; end
    endcase
  end

  // Internal decode is active low; internal space wins over any region
  assign prog_hit_n = ~(prog_select_enable && !internal_space_hit
                       && internal_address_in >= prog_lo);
  assign gen_hit_n  = ~(gen_select_enable && !internal_space_hit && prog_hit_n
                       && internal_address_in >= gen_lo && internal_address_in < prog_lo);

  // Gated off completely when the interface is not built in
  assign active    = INTERFACE_BUILD_ENABLE && cycle_valid;
  assign ext_cycle = active && !internal_space_hit;
  assign visible   = active && internal_space_hit && internal_cycle_visibility;
  assign external_access = ext_cycle;

  // Software wait counts; both reset to three, the maximum program count
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prog_ws_reg <= PROG_WAIT_RESET;
      gen_ws_reg  <= GEN_WAIT_RESET;
    end else begin
      if (prog_wait_write) begin
        prog_ws_reg <= prog_wait_count;
      end
      if (gen_wait_write) begin
        gen_ws_reg <= gen_wait_count;
      end
    end
  end

  // Wait count source for the cycle under way
  always_comb begin
    if (cur_gen_reg && gen_wait_external) begin
      wait_sel = ext_data_in[WAIT_W-1:0];
    end else if (cur_gen_reg) begin
      wait_sel = gen_ws_reg;
    end else begin
      wait_sel = {1'b0, prog_ws_reg};
    end
  end

  // Cycle phases: T4 samples the count, then the counter stalls the CPU
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_reg   <= PH_IDLE;
      cur_gen_reg <= 1'b0;
    end else begin
      unique case (phase_reg)
        PH_IDLE: begin
          if (ext_cycle && (!prog_hit_n || !gen_hit_n)) begin
            phase_reg   <= PH_T4;
            cur_gen_reg <= !gen_hit_n;
          end
        end
        PH_T4:   phase_reg <= (wait_sel != WAIT_ZERO) ? PH_WAIT : PH_DONE;
        PH_WAIT: begin
          if (!cnt_busy) begin
            phase_reg <= PH_DONE;
          end
        end
        PH_DONE: phase_reg <= PH_IDLE;
      endcase
    end
  end

  assign load_wait = (phase_reg == PH_T4);

  wait_counter #(
    .W(WAIT_W)
  ) u_wait (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .load     (load_wait),
    .count_in (wait_sel),
    .busy     (cnt_busy)
  );

  // Stall only external region cycles, for the chosen waits plus one; zero soft waits never stall
  always_comb begin
    internal_wait_request = 1'b0;
    if (ext_cycle) begin
      if (phase_reg == PH_IDLE) begin
        // Zero soft waits never stall; a hardware count is unknown until T4
        if (!gen_hit_n) begin
          internal_wait_request = gen_wait_external || (gen_ws_reg != WAIT_ZERO);
        end else if (!prog_hit_n) begin
          internal_wait_request = ({1'b0, prog_ws_reg} != WAIT_ZERO);
        end
      end else if (phase_reg == PH_T4) begin
        internal_wait_request = (wait_sel != WAIT_ZERO);
      end else if (phase_reg == PH_WAIT) begin
        internal_wait_request = (u_wait.cnt_reg > WAIT_ONE);
      end
    end
  end

  // Pins: low-noise freezes them, high-performance follows the bus
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      addr_reg  <= '0;
      dout_reg  <= '0;
      drive_reg <= 1'b0;
    end else if (!low_noise_mode && INTERFACE_BUILD_ENABLE) begin
      addr_reg  <= internal_address_in;
      if (!internal_read_write || visible) begin
        dout_reg <= internal_data_in;
      end
      drive_reg <= !internal_read_write || visible;
    end else if (ext_cycle || visible) begin
      addr_reg  <= internal_address_in;
      // External reads leave the last written value on the data pins; visible internal cycles load internal_data_in
      if (!internal_read_write || visible) begin
        dout_reg <= internal_data_in;
      end
      drive_reg <= !internal_read_write || visible;
    end else begin
      drive_reg <= 1'b0;
    end
  end

  // Strobes registered from the internal read/write line, selects from the region decode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_reg   <= 1'b0;
      wr_reg   <= 1'b0;
      psel_reg <= 1'b0;
      gsel_reg <= 1'b0;
    end else begin
      rd_reg   <= (ext_cycle || visible) && internal_read_write;
      wr_reg   <= (ext_cycle || visible) && !internal_read_write;
      psel_reg <= ext_cycle && !prog_hit_n;
      gsel_reg <= ext_cycle && !gen_hit_n;
    end
  end

  // Capture only once the read strobe is out, and never the T4 wait count
  assign read_capture = rd_reg && (psel_reg || gsel_reg)
                        && !(phase_reg == PH_T4 && cur_gen_reg && gen_wait_external);

  // Read data returned to the internal bus from the external pins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      idb_reg <= '0;
    end else if (read_capture) begin
      idb_reg <= ext_data_in;
    end
  end

  assign internal_data_bus       = idb_reg;
  assign ext_addr                = addr_reg;
  assign ext_addr_oe_n           = !INTERFACE_BUILD_ENABLE;
  assign ext_data_out            = dout_reg;
  // External count lines released during T4 when hardware supplies waits
  assign ext_data_oe_n           = !drive_reg || (phase_reg == PH_T4 && cur_gen_reg
                                   && gen_wait_external);
  assign external_read_strobe_n  = !rd_reg;
  assign external_write_strobe_n = !wr_reg;
  assign program_region_select   = psel_reg ^ !prog_select_polarity;
  assign general_region_select   = gsel_reg ^ !gen_select_polarity;

  // Drive strobe, active low during T4; only of a general-region cycle when STROBE_T4_SEL is chosen
  assign wait_value_drive_strobe = !(phase_reg == PH_T4 && (strobe_function != STROBE_T4_SEL
                                   || cur_gen_reg));
  assign wait_value_drive_strobe_oe_n = (strobe_function == STROBE_OFF);

  AST_NO_WAIT_INTERNAL: assert property (@(posedge clk_sys) disable iff (srst)
    internal_space_hit |-> !internal_wait_request)
    else $error("wait request on internal cycle");
  AST_RESET_WAITS: assert property (@(posedge clk_sys)
    $past(srst) |-> prog_ws_reg == PROG_WAIT_RESET && gen_ws_reg == GEN_WAIT_RESET)
    else $error("wait counts not three after reset");
  AST_T4_FOLLOWS: assert property (@(posedge clk_sys) disable iff (srst)
    phase_reg == PH_T4 |=> phase_reg inside {PH_WAIT, PH_DONE})
    else $error("T4 not followed by wait or done");
  AST_WAIT_BOUND: assert property (@(posedge clk_sys) disable iff (srst)
    phase_reg == PH_T4 |-> ##[1:9] phase_reg == PH_DONE)
    else $error("wait phase overran seven waits");
  AST_READ_STROBE: assert property (@(posedge clk_sys) disable iff (srst)
    !external_read_strobe_n |-> $past(ext_cycle || visible))
    else $error("read strobe without external or visible cycle");
  AST_WRITE_STROBE: assert property (@(posedge clk_sys) disable iff (srst)
    !external_write_strobe_n |-> $past(!internal_read_write))
    else $error("write strobe on a read");
  AST_LOW_NOISE_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
    (low_noise_mode && !ext_cycle && !visible) |=> $stable(ext_addr))
    else $error("address moved between external cycles");
  AST_READ_DATA: assert property (@(posedge clk_sys) disable iff (srst)
    read_capture |=> internal_data_bus == $past(ext_data_in))
    else $error("read data not passed inward");
  AST_PRIORITY: assert property (@(posedge clk_sys) disable iff (srst)
    internal_space_hit |=> !psel_reg && !gsel_reg)
    else $error("select asserted for internal access");
endmodule

// ==== src/ext_bus_pkg.sv ====
// Constants shared by the external bus interface and its wait-state counter.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
package ext_bus_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int WAIT_W = 3;

  // Wait-state limits and reset values
  localparam logic [1:0] PROG_WAIT_RESET = 2'h3;
  localparam logic [2:0] GEN_WAIT_RESET  = 3'h3;
  localparam logic [2:0] WAIT_ZERO       = 3'h0;
  localparam logic [2:0] WAIT_ONE        = 3'h1;

  // Chip-select region map choices
  localparam logic [1:0] MAP_A = 2'h0;
  localparam logic [1:0] MAP_B = 2'h1;
  localparam logic [1:0] MAP_C = 2'h2;
  localparam logic [1:0] MAP_D = 2'h3;

  // Region bounds: program region always covers the top, vectors included
  localparam logic [15:0] PROG_LO_A = 16'h8000;
  localparam logic [15:0] PROG_LO_B = 16'h4000;
  localparam logic [15:0] PROG_LO_C = 16'hc000;
  localparam logic [15:0] PROG_LO_D = 16'h8000;
  localparam logic [15:0] GEN_LO_A  = 16'h1000;
  localparam logic [15:0] GEN_LO_B  = 16'h1000;
  localparam logic [15:0] GEN_LO_C  = 16'h1000;
  localparam logic [15:0] GEN_LO_D  = 16'h0000;

  // Bus cycle phases; T4 is where an external wait count is sampled
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_T4    = 2'b01,
    PH_WAIT  = 2'b10,
    PH_DONE  = 2'b11
  } phase_t;

  // Pin function choices for the wait-value drive strobe
  localparam logic [1:0] STROBE_OFF    = 2'h0;
  localparam logic [1:0] STROBE_T4_SEL = 2'h1;

endpackage

// ==== src/wait_counter.sv ====
// Counts down the wait states of one external bus cycle.
// Assumes load is a one-cycle pulse at the end of the sampling phase.
`timescale 1ns/1ps
module wait_counter
  import ext_bus_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic         load,
  input  wire logic [W-1:0] count_in,
  output logic              busy
);
  logic [W-1:0] cnt_reg;

  // Loaded with the selected count; one wait state per clock cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= count_in;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign busy = (cnt_reg != '0);
endmodule

// ==== testbench/ext_device_model.sv ====
// Behavioural external memory that also drives a wait count in T4.
// Assumes active-low strobes from the bus interface on the system clock.
`timescale 1ns/1ps
module ext_device_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        wv_n,
  input  wire logic        wv_oe_n,
  input  wire logic [2:0]  wait_cnt
);
  logic [7:0] mem [256];
  logic [7:0] last_reg = 8'h00;
  // Store on the clock while the write strobe is low; remember what the bus showed
  always @(posedge clk_sys) begin
    if (!wr_n) mem[addr[7:0]] <= wdata;
    last_reg <= rdata;
  end
  // Released bus shows the inverse of its last value, so a stale capture is caught
  always_comb begin
    if (!wv_oe_n && !wv_n) rdata = {5'h00, wait_cnt};
    else if (!rd_n) rdata = mem[addr[7:0]];
    else rdata = ~last_reg;
  end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the external bus interface.
// Assumes the device model answers on the expansion pins.
`timescale 1ns/1ps
module tb_top;
  import ext_bus_pkg::*;
  logic        clk_sys = 0, srst = 1, internal_read_write = 1, cycle_valid = 0;
  logic        internal_space_hit = 0, low_noise_mode = 1, internal_cycle_visibility = 0;
  logic        prog_select_enable = 1, prog_select_polarity = 0, prog_wait_write = 0;
  logic        gen_select_enable = 1, gen_select_polarity = 0, gen_wait_write = 0;
  logic        gen_wait_external = 0, internal_wait_request, ext_addr_oe_n, ext_data_oe_n;
  logic        external_read_strobe_n, external_write_strobe_n, external_access;
  logic        program_region_select, general_region_select;
  logic        wait_value_drive_strobe, wait_value_drive_strobe_oe_n;
  logic [15:0] internal_address_in = 16'h0000, ext_addr;
  logic [7:0]  internal_data_in = 8'h00, internal_data_bus, ext_data_out, ext_data_in;
  logic [1:0]  region_map = 2'h0, prog_wait_count = 2'h3, strobe_function = 2'h0;
  logic [2:0]  gen_wait_count = 3'h3, wc = 3'h0;
  logic        saw_rd, saw_wr, saw_ps, saw_gs, saw_ext;
  int          nw, n_errors = 0, samples_checked = 0, cyc = 0;

  external_bus_interface #(.INTERFACE_BUILD_ENABLE(1'b1)) external_bus_interface_inst (.*);
  ext_device_model ext_device_model_inst (.clk_sys(clk_sys), .addr(ext_addr),
    .wdata(ext_data_out), .rdata(ext_data_in), .rd_n(external_read_strobe_n),
    .wr_n(external_write_strobe_n), .wv_n(wait_value_drive_strobe),
    .wv_oe_n(wait_value_drive_strobe_oe_n), .wait_cnt(wc));

  // Clock and a hang guard well above the few hundred cycles the run needs
  initial forever #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      final_report;
    end
  end

  task tick; @(posedge clk_sys); #2; endtask
  task check(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, s, e);
    end
  endtask
  function automatic int ew(input int n); return (n == 0) ? 0 : n + 1; endfunction
  task setw(input logic [1:0] p, input logic [2:0] g);
    prog_wait_count <= p; gen_wait_count <= g; prog_wait_write <= 1; gen_wait_write <= 1;
    tick;
    prog_wait_write <= 0; gen_wait_write <= 0;
    tick;
  endtask
  // One access held while stalled, then released; pins are watched throughout
  task acc(input logic [15:0] a, input logic rd, input logic ih, input logic [7:0] d);
    nw = 0; {saw_rd, saw_wr, saw_ps, saw_gs, saw_ext} = '0;
    internal_address_in <= a; internal_read_write <= rd; internal_data_in <= d;
    internal_space_hit <= ih; cycle_valid <= 1;
    for (int k = 0; k < 24; k++) begin
      #10;
      if (internal_wait_request === 1'b1) nw++;
      saw_rd |= (external_read_strobe_n === 1'b0);
      saw_wr |= (external_write_strobe_n === 1'b0);
      saw_ps |= (program_region_select === prog_select_polarity);
      saw_gs |= (general_region_select === gen_select_polarity);
      saw_ext |= (external_access === 1'b1);
      if (internal_wait_request === 1'b0 && k >= 1 && k >= nw) cycle_valid <= 0;
      if (k == nw + 5) break;
      tick;
    end
    tick;
  endtask

  task t_reset;
    acc(16'h9000, 1, 0, 8'h00); check(nw, 4);
    check(saw_ps, 1);
    acc(16'h2000, 1, 0, 8'h00); check(nw, 4);
    check(saw_gs, 1);
  endtask
  task t_waits;
    for (int i = 0; i < 4; i++) begin
      setw(i[1:0], 3'h3); acc(16'h8100, 1, 0, 8'h00);
      check(nw, ew(i));
      check(saw_rd, 1);
    end
    for (int i = 0; i < 8; i++) begin
      setw(2'h0, i[2:0]); acc(16'h2000, 0, 0, 8'h5a);
      check(nw, ew(i));
    end
    gen_wait_external <= 1; strobe_function <= STROBE_T4_SEL; setw(2'h0, 3'h0);
    for (int i = 0; i < 8; i++) begin
      wc <= i[2:0]; acc(16'h2000, 1, 0, 8'h00);
      check(nw, i + 1);
    end
    gen_wait_external <= 0; strobe_function <= STROBE_OFF;
  endtask
  task t_data;
    setw(2'h0, 3'h0); prog_select_polarity <= 1; tick;
    acc(16'h8123, 0, 0, 8'ha5);
    check(saw_wr, 1);
    check(ext_data_out, 8'ha5);
    check(saw_ps, 1);
    acc(16'h8123, 1, 0, 8'h00);
    check(internal_data_bus, 8'ha5);
    check({saw_rd, saw_wr}, 2'b10);
    prog_select_polarity <= 0;
  endtask
  task t_internal;
    acc(16'h9000, 0, 1, 8'h3c);
    check(nw, 0);
    check({saw_rd, saw_wr, saw_ext}, 3'b000);
    check(saw_ps, 0);
    check(ext_addr, 16'h8123);
    check(ext_data_out, 8'ha5);
    internal_cycle_visibility <= 1;
    acc(16'h0100, 0, 1, 8'h3c);
    check(saw_wr, 1);
    check(ext_data_out, 8'h3c);
    internal_cycle_visibility <= 0; low_noise_mode <= 0;
    acc(16'h0200, 1, 1, 8'h00);
    check(ext_addr, 16'h0200);
    low_noise_mode <= 1;
  endtask
  task t_map;
    for (int m = 0; m < 4; m++) begin
      region_map <= m[1:0]; tick;
      acc(16'h4000, 1, 0, 8'h00);
      check({saw_ps, saw_gs}, (m == 1) ? 2'b10 : 2'b01);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Reset for four cycles, then each scenario in turn
  initial begin
    repeat (4) tick;
    srst <= 0;
    tick;
    t_reset;
    t_waits;
    t_data;
    t_internal;
    t_map;
    final_report;
  end
endmodule
